/* inc/alc_map.svh */
// Purpose: Register map and constants of the actuator loop control block
// Assumes: Eight-bit register port behind the device serial interface
// Notes:   Definitions only
`ifndef ALC_MAP_SVH
`define ALC_MAP_SVH

// ==========================================================
// Register location and reset value
`define ALC_CTRL_ADDR 8'h08
`define ALC_CTRL_RST 8'h88
`define ALC_RDATA_NONE 8'h00

// ==========================================================
// Field positions of the control register
`define ALC_BIT_TYPE 7
`define ALC_BIT_OPEN 6
`define ALC_BIT_HYB 5
`define ALC_BIT_OLBRK 4
`define ALC_BIT_SBBRK 3
`define ALC_BIT_SLOPE 2
`define ALC_RSVD_HI 1
`define ALC_RSVD_LO 0

// ==========================================================
// Trigger pin function code and slope threshold
`define ALC_TRIG_LEVEL 2'h1
`define ALC_SLOPE_MIN 9'h020

`endif

/* inc/alc_pkg.sv */
// Purpose: Shared types of the actuator loop control block
// Assumes: Constants live in alc_map.svh
// Notes:   Types only
package alc_pkg;

  // ==========================================================
  // Types
  typedef logic [7:0] alc_byte_t;

  typedef enum logic {
    ALC_SB_IDLE,
    ALC_SB_BRAKE
  } alc_sb_state_t;

endpackage : alc_pkg

/* sim/alc_act_model.sv */
// Purpose: Drive engine and actuator stand-in for braking
// Assumes: standby_brake is sampled on rising clk
// Notes: Slow mode stretches the braking phase
`timescale 1ns/1ps
module alc_act_model (
  // Clock
  input wire logic clk,
  // Bench commands
  input wire logic spin,
  input wire logic slow,
  // Block request and answers
  input wire logic standby_brake,
  output logic actuator_moving,
  output logic brake_done
);
  // ==========================================================
  // Back-EMF follows the bench command with no lag
  assign actuator_moving = spin;
  // One or six cycles of braking, so prompt and slow answers both occur
  logic done_r = 1'b0;
  assign brake_done = done_r;
  always @(posedge clk) begin
    if (standby_brake === 1'b1 && done_r === 1'b0) begin
      repeat (slow ? 6 : 1) @(posedge clk);
      #1 done_r = 1'b1;
      @(posedge clk);
      #1 done_r = 1'b0;
    end
  end
endmodule : alc_act_model

/* sim/tb_actuator_loop_control_config.sv */
// Purpose: Self-checking bench of the loop control register block
// Assumes: Inputs change 1 ns after rising clk
// Notes: Results are matched against a queue of expected notes
`timescale 1ns/1ps
`include "alc_map.svh"
module tb_actuator_loop_control_config;
  // ==========================================================
  // Signals; the bench drivers are all given values at time zero
  logic clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic trigger_irq_pin = 1'b1, sample_valid = 1'b0, playing = 1'b0;
  logic standby_timer_req = 1'b0, spin = 1'b0, slow = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, sample = 8'h00;
  logic [1:0] trigger_pin_function = 2'h0;
  logic [7:0] reg_rdata, cfg, prev = 8'h00;
  logic actuator_moving, brake_done, actuator_type_sel, hybrid_loop_en;
  logic drive_open_loop, sample_brake, standby_brake, standby_enter;
  logic tr, ts, brk_seen = 1'b0;
  logic [7:0] q[$];
  logic [5:0] tbl [8] = '{6'h0E, 6'h0F, 6'h0C, 6'h0A, 6'h06, 6'h3E, 6'h1E, 6'h36};
  int errors = 0, cmp_count = 0, cyc = 0, seed = 17, k, n;

  alc_top u_alc_top (.clk(clk), .nrst(nrst), .clk_en(clk_en), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .trigger_pin_function(trigger_pin_function), .trigger_irq_pin(trigger_irq_pin),
    .sample_valid(sample_valid), .sample(sample), .playing(playing),
    .actuator_moving(actuator_moving), .standby_timer_req(standby_timer_req),
    .brake_done(brake_done), .actuator_type_sel(actuator_type_sel),
    .hybrid_loop_en(hybrid_loop_en), .drive_open_loop(drive_open_loop),
    .sample_brake(sample_brake), .standby_brake(standby_brake),
    .standby_enter(standby_enter));
  alc_act_model u_alc_act_model (.clk(clk), .spin(spin), .slow(slow),
    .standby_brake(standby_brake), .actuator_moving(actuator_moving),
    .brake_done(brake_done));

  // ==========================================================
  // Clock and cycle ceiling
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end

  // ==========================================================
  // Compare, verdict and drivers
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  // One register access; a read notes its expected byte first
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
    if (!w) q.push_back(v);
    @(posedge clk);
    #1;
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = v;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask : bus

  // One sample; slope is the magnitude of the step from the last sample
  task automatic smp(input logic [7:0] s);
    logic [8:0] dif;
    logic brk;
    dif = {s[7], s} - {prev[7], prev};
    if (dif[8]) dif = -dif;
    brk = cfg[6] & cfg[4] & (s[7] | (s == 8'h00));
    q.push_back({6'h00, cfg[6] ? !brk : cfg[5] & cfg[2] & (dif < `ALC_SLOPE_MIN), brk});
    prev = s;
    @(posedge clk);
    #1;
    sample_valid = 1'b1;
    sample = s;
    @(posedge clk);
    #1;
    sample_valid = 1'b0;
  endtask : smp

  // Standby request by timer or pin fall; e of 0 means none may follow
  task automatic sby(input logic pin, input logic [7:0] e);
    int i;
    if (e != 8'h00) q.push_back(e);
    @(posedge clk);
    #1;
    trigger_irq_pin = !pin;
    standby_timer_req = !pin;
    @(posedge clk);
    #1;
    standby_timer_req = 1'b0;
    for (i = 0; i < 30; i++) begin
      @(posedge clk);
      #2;
      if (standby_enter === 1'b1) break;
    end
    @(posedge clk);
    #1;
    trigger_irq_pin = 1'b1;
    repeat (4) @(posedge clk);
  endtask : sby

  // ==========================================================
  // Watcher: read data and decisions land at the taking edge
  always @(posedge clk) begin
    tr = reg_rd & clk_en & nrst;
    ts = sample_valid & clk_en & nrst;
    #2;
    if (tr | ts) check(tr ? reg_rdata : {6'h00, drive_open_loop, sample_brake}, q.pop_front());
    if (standby_brake === 1'b1) brk_seen = 1'b1;
    if (standby_enter === 1'b1) begin
      check(brk_seen ? 8'h02 : 8'h01, q.pop_front());
      brk_seen = 1'b0;
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    #1;
    nrst = 1'b1;
    bus(1'b0, `ALC_CTRL_ADDR, `ALC_CTRL_RST);
    check({6'h00, actuator_type_sel, hybrid_loop_en}, 8'h02);
    // Random byte, unmapped place and a frozen write
    cfg = 8'($random(seed));
    bus(1'b1, `ALC_CTRL_ADDR, cfg);
    bus(1'b0, `ALC_CTRL_ADDR, cfg);
    check({6'h00, actuator_type_sel, hybrid_loop_en}, {6'h00, cfg[7], cfg[5]});
    bus(1'b1, 8'h09, ~cfg);
    bus(1'b0, 8'h09, `ALC_RDATA_NONE);
    clk_en = 1'b0;
    bus(1'b1, `ALC_CTRL_ADDR, ~cfg);
    clk_en = 1'b1;
    bus(1'b0, `ALC_CTRL_ADDR, cfg);
    // Every loop, brake and slope setting; type stays set first
    for (k = 0; k < 16; k++) begin
      cfg = {1'b1, k[3], k[2], k[1], 1'b1, k[0], 2'b00};
      bus(1'b1, `ALC_CTRL_ADDR, cfg);
      smp(8'h00);
      for (n = 0; n < 6; n++) smp(8'($random(seed)));
    end
    // Standby cases: fn, pin, brake enable, playing, moving, slow
    // Last case is a level-enable release with braking off
    for (k = 0; k < 8; k++) begin
      bus(1'b1, `ALC_CTRL_ADDR, {4'h8, tbl[k][3], 3'h0});
      trigger_pin_function = tbl[k][5] ? `ALC_TRIG_LEVEL : 2'h0;
      playing = tbl[k][2];
      spin = tbl[k][1];
      slow = tbl[k][0];
      sby(tbl[k][4], (tbl[k][4] & !tbl[k][5]) ? 8'h00 : (&tbl[k][3:1] ? 8'h02 : 8'h01));
    end
    check(8'(q.size()), 8'h00);
    results();
  end
endmodule : tb_actuator_loop_control_config

/* verilog/alc_standby_seq.sv */
// Purpose: Go-to-standby sequencer with optional braking phase
// Assumes: go_req is a one-cycle pulse on clk; brake_done comes from the drive engine
// Notes:   Requests arriving during a braking phase are absorbed by it
`timescale 1ns/1ps
`include "alc_map.svh"
module alc_standby_seq (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Request and conditions
  input wire logic go_req,
  input wire logic auto_brake_en,
  input wire logic playing,
  input wire logic moving,
  input wire logic brake_done,
  // Results
  output logic brake_active,
  output logic standby_enter
);

  // ==========================================================
  // State
  alc_pkg::alc_sb_state_t state_ff;
  alc_pkg::alc_sb_state_t nxt_state;
  logic brake_ff;
  logic standby_ff;
  logic nxt_standby;
  logic need_brake;

  // Braking only pays off when something was playing and still moves
  assign need_brake = auto_brake_en & playing & moving; // R8 R9 R15

  // Next state
  always_comb begin
    nxt_state = state_ff;
    nxt_standby = 1'b0;
    case (state_ff)
      alc_pkg::ALC_SB_IDLE: begin
        if (go_req) begin
          if (need_brake) begin
            nxt_state = alc_pkg::ALC_SB_BRAKE; // R8
          end else begin
            nxt_standby = 1'b1; // R9 R10
          end
        end
      end
      alc_pkg::ALC_SB_BRAKE: begin
        if (brake_done) begin
          nxt_state = alc_pkg::ALC_SB_IDLE;
          nxt_standby = 1'b1; // R8
        end
      end
      default: begin
        nxt_state = alc_pkg::ALC_SB_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff <= alc_pkg::ALC_SB_IDLE;
      brake_ff <= 1'b0;
      standby_ff <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      brake_ff <= (nxt_state == alc_pkg::ALC_SB_BRAKE);
      standby_ff <= nxt_standby;
    end
  end

  assign brake_active = brake_ff;
  assign standby_enter = standby_ff;

  // ==========================================================
  // Checks
  sb_brake_start_a: assert property (@(posedge clk) disable iff (!nrst) // R8
    clk_en && go_req && need_brake && state_ff == alc_pkg::ALC_SB_IDLE
    |=> brake_active && !standby_enter)
    else $error("brake phase not started");
  sb_still_skip_a: assert property (@(posedge clk) disable iff (!nrst) // R9
    clk_en && go_req && auto_brake_en && !moving && state_ff == alc_pkg::ALC_SB_IDLE
    |=> standby_enter && !brake_active)
    else $error("still actuator was braked");
  sb_immediate_a: assert property (@(posedge clk) disable iff (!nrst) // R10
    clk_en && go_req && !auto_brake_en && state_ff == alc_pkg::ALC_SB_IDLE
    |=> standby_enter && !brake_active)
    else $error("standby not immediate");
  sb_brake_end_a: assert property (@(posedge clk) disable iff (!nrst) // R8
    clk_en && brake_active && brake_done |=> standby_enter && !brake_active)
    else $error("brake phase did not end in standby");
  sb_brake_cov: cover property (@(posedge clk) disable iff (!nrst)
    brake_active ##[1:20] standby_enter);

endmodule : alc_standby_seq

/* verilog/alc_top.sv */
// Purpose: Actuator loop control register and the drive decisions it steers
// Assumes: Register port comes from the serial decoder on clk; pin is asynchronous
// Notes:   Sample decisions update only on sample_valid
//
// Behaviour
// R1 - Bit 7 selects actuator type, reset one
// R2 - Host sets type before level calibration
// R3 - Bit 6 chooses closed or open loop
// R4 - Bit 5 chooses full or hybrid closed loop
// R5 - Open-loop auto-brake brakes on non-positive samples
// R6 - Positive samples still play open loop
// R7 - Open-loop auto-brake resets off
// R8 - Standby auto-brake brakes before standby while playing, reset one
// R9 - Not moving: standby without braking
// R10 - Brake disabled: standby at once
// R11 - Slope check: open loop unless big transition
// R12 - Slope check ignored without hybrid loop
// R13 - Level-enable pin release requests standby
// R14 - Bits 1:0 reserved, stored, no effect
// R15 - Movement judged from back-EMF at request
`timescale 1ns/1ps
`include "alc_map.svh"
module alc_top (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Trigger pin and its function field
  input wire logic [1:0] trigger_pin_function,
  input wire logic trigger_irq_pin,
  // Drive engine status
  input wire logic sample_valid,
  input wire logic [7:0] sample,
  input wire logic playing,
  input wire logic actuator_moving,
  input wire logic standby_timer_req,
  input wire logic brake_done,
  // Settings and decisions to the drive engine
  output logic actuator_type_sel,
  output logic hybrid_loop_en,
  output logic drive_open_loop,
  output logic sample_brake,
  output logic standby_brake,
  output logic standby_enter
);

  // ==========================================================
  // Helpers
  // Non-positive test of a signed sample
  function automatic logic alc_le_zero(input logic [7:0] s);
    alc_le_zero = s[7] | (s == 8'h00);
  endfunction : alc_le_zero

  // Magnitude of a nine-bit signed difference
  function automatic logic [8:0] alc_abs9(input logic [8:0] d);
    alc_abs9 = d[8] ? (9'h000 - d) : d;
  endfunction : alc_abs9

  // ==========================================================
  // Register
  alc_pkg::alc_byte_t ctrl_ff;
  alc_pkg::alc_byte_t rdata_ff;
  logic addr_hit;
  logic wr_hit;

  assign addr_hit = (reg_addr == `ALC_CTRL_ADDR);
  assign wr_hit = reg_wr & addr_hit;

  // All eight bits are stored, reserved ones too, so reads return writes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_ff <= `ALC_CTRL_RST; // R1 R3 R4 R7 R8 R14
    end else if (clk_en && wr_hit) begin
      ctrl_ff <= reg_wdata; // R14
    end
  end

  // Read data; unmapped addresses answer zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_ff <= `ALC_RDATA_NONE;
    end else if (clk_en && reg_rd) begin
      rdata_ff <= addr_hit ? ctrl_ff : `ALC_RDATA_NONE;
    end
  end

  // ==========================================================
  // Field decode
  logic open_sel;
  logic hyb_sel;
  logic ol_brk_en;
  logic sb_brk_en;
  logic slope_active;

  assign open_sel = ctrl_ff[`ALC_BIT_OPEN]; // R3
  assign hyb_sel = ctrl_ff[`ALC_BIT_HYB]; // R4
  assign ol_brk_en = ctrl_ff[`ALC_BIT_OLBRK];
  assign sb_brk_en = ctrl_ff[`ALC_BIT_SBBRK];
  // Slope check only counts in hybrid loop
  assign slope_active = hyb_sel & ctrl_ff[`ALC_BIT_SLOPE]; // R12

  // ==========================================================
  // Per-sample loop decision
  alc_pkg::alc_byte_t prev_ff;
  logic open_ff;
  logic brake_ff;
  logic [8:0] diff;
  logic big_step;
  logic le_zero;
  logic nxt_open;
  logic nxt_brake;

  assign diff = {sample[7], sample} - {prev_ff[7], prev_ff};
  assign big_step = (alc_abs9(diff) >= `ALC_SLOPE_MIN); // R11
  assign le_zero = alc_le_zero(sample);
  // Open loop brakes through closed loop; slope check may force open loop
  assign nxt_brake = open_sel & ol_brk_en & le_zero; // R5
  assign nxt_open = open_sel ? ~nxt_brake : (slope_active & ~big_step); // R3 R6 R11

  // Decisions hold between samples so the engine sees a stable setting
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev_ff <= 8'h00;
      open_ff <= 1'b0;
      brake_ff <= 1'b0;
    end else if (clk_en && sample_valid) begin
      prev_ff <= sample;
      open_ff <= nxt_open; // R3 R5 R6 R11
      brake_ff <= nxt_brake; // R5
    end
  end

  // ==========================================================
  // Trigger pin synchroniser and release detect
  logic pin_s1_ff;
  logic pin_s2_ff;
  logic pin_prev_ff;
  logic pin_release;
  logic go_req;

  // Two stages before any logic looks at the pin
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      pin_prev_ff <= 1'b0;
    end else if (clk_en) begin
      pin_s1_ff <= trigger_irq_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_prev_ff <= pin_s2_ff;
    end
  end

  assign pin_release = pin_prev_ff & ~pin_s2_ff;
  assign go_req = standby_timer_req
    | (pin_release & (trigger_pin_function == `ALC_TRIG_LEVEL)); // R13

  // ==========================================================
  // Standby sequencer
  alc_standby_seq u_sb (
    .clk(clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .go_req(go_req),
    .auto_brake_en(sb_brk_en),
    .playing(playing),
    .moving(actuator_moving), // R15
    .brake_done(brake_done),
    .brake_active(standby_brake),
    .standby_enter(standby_enter)
  );

  // Outputs straight from flops
  assign reg_rdata = rdata_ff;
  assign actuator_type_sel = ctrl_ff[`ALC_BIT_TYPE]; // R1
  assign hybrid_loop_en = hyb_sel; // R4
  assign drive_open_loop = open_ff;
  assign sample_brake = brake_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  reset_value_a: assert property ($rose(nrst) |-> ctrl_ff == `ALC_CTRL_RST) // R7
    else $error("control register reset value wrong");
  type_write_a: assert property (clk_en && wr_hit // R1
    |=> actuator_type_sel == $past(reg_wdata[`ALC_BIT_TYPE]))
    else $error("actuator type not written");
  // Reserved bits written must come back on a read two cycles later
  rsvd_readback_a: assert property (clk_en && wr_hit ##1 !(clk_en && wr_hit) // R14
    ##1 clk_en && reg_rd && addr_hit
    |=> reg_rdata[`ALC_RSVD_HI:`ALC_RSVD_LO] == $past(reg_wdata[`ALC_RSVD_HI:`ALC_RSVD_LO], 3))
    else $error("reserved bits not read back");
  ol_brake_a: assert property (clk_en && sample_valid && open_sel && ol_brk_en // R5
    && le_zero |=> sample_brake && !drive_open_loop)
    else $error("open loop brake missing");
  ol_positive_a: assert property (clk_en && sample_valid && open_sel && !le_zero // R6
    |=> drive_open_loop && !sample_brake)
    else $error("positive sample left open loop");
  closed_loop_a: assert property (clk_en && sample_valid && !open_sel && !slope_active // R3
    |=> !drive_open_loop && !sample_brake)
    else $error("closed loop not kept");
  slope_gate_a: assert property (clk_en && sample_valid && !open_sel && hyb_sel // R11
    && ctrl_ff[`ALC_BIT_SLOPE] |=> drive_open_loop == !$past(big_step))
    else $error("slope check decision wrong");
  slope_ignore_a: assert property (clk_en && sample_valid && !open_sel && !hyb_sel // R12
    |=> !drive_open_loop)
    else $error("slope check acted without hybrid");
  pin_standby_a: assert property (clk_en && pin_release // R13
    && trigger_pin_function == `ALC_TRIG_LEVEL && !standby_brake && !sb_brk_en
    |=> standby_enter)
    else $error("pin release gave no standby");

  ol_brake_cov: cover property (sample_valid && open_sel && ol_brk_en && le_zero);
  slope_cov: cover property (sample_valid && slope_active && big_step);
  pin_cov: cover property (pin_release ##1 standby_enter);

endmodule : alc_top
